// ==== rwlm_pkg.sv ====
// types shared by the region write lock manager
package rwlm_pkg;

  typedef enum logic [1:0] {
    RWLM_MODE_SUPPLY,
    RWLM_MODE_PASSWORD,
    RWLM_MODE_PERMANENT
  } rwlm_mode_e;

  typedef enum logic [1:0] {
    RWLM_ST_INIT,
    RWLM_ST_IDLE,
    RWLM_ST_BUSY,
    RWLM_ST_HOLD
  } rwlm_state_e;

  typedef struct packed {
    logic erase_err;
    logic prog_err;
    logic busy;
  } rwlm_status_s;

  typedef struct packed {
    logic region2_write_allow;
    logic region3_write_allow;
    logic pointer_write_allow;
    logic region3_read_valid;
  } rwlm_access_s;

endpackage : rwlm_pkg

// ==== rwlm_region_write_lock_manager.sv ====
// security region and pointer register write lock manager with spi front
`timescale 1ns/1ps
`include "rwlm_region_write_lock_manager_map.svh"

module rwlm_region_write_lock_manager #(
  parameter int PROG_CYCLES = `RWLM_PAGE_PROG_CYCLES,
  parameter int RATE_CYCLES = `RWLM_RATE_CYCLES
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 por_in,
  input  wire logic                 sck_in,
  input  wire logic                 cs_n_in,
  input  wire logic                 mosi_in,
  input  wire logic [1:0]           region_lock_bits_in,
  output rwlm_pkg::rwlm_status_s    status_out,
  output rwlm_pkg::rwlm_access_s    access_out,
  output logic [7:0]                volatile_protection_state_out,
  output logic [7:0]                protection_mode_config_out,
  output logic [7:0]                pointer_boundary_register_out,
  output logic                      per_block_lock_protect_out,
  output logic [7:0]                register_read_data_out,
  output logic [63:0]               password_read_data_out,
  output logic                      frame_reject_out
);
  import rwlm_pkg::*;
  function automatic rwlm_mode_e mode_of(input logic [7:0] cfg);
    if (!cfg[`RWLM_CFG_PASS_BIT])
      mode_of = RWLM_MODE_PASSWORD;
    else if (!cfg[`RWLM_CFG_PERM_BIT])
      mode_of = RWLM_MODE_PERMANENT;
    else
      mode_of = RWLM_MODE_SUPPLY;
  endfunction : mode_of
  localparam int NBYTES = 9;
  logic              fresh_q;
  logic [6:0]        bit_cnt_q;
  logic [7:0]        frame_bytes_q [0:NBYTES-1];
  wire               link_rst   = rst_in | por_in;
  wire               frame_idle = cs_n_in | link_rst;
  wire [3:0]         wr_idx     = fresh_q ? 4'h0 : bit_cnt_q[6:3];
  wire [2:0]         wr_bit     = fresh_q ? 3'h7 : ~bit_cnt_q[2:0];
  // set while deselected; first sck edge of a frame restarts the count
  always_ff @(posedge sck_in or posedge frame_idle)
  begin
    if (frame_idle)
      fresh_q <= 1'b1;
    else
      fresh_q <= 1'b0;
  end

  always_ff @(posedge sck_in or posedge link_rst)
  begin
    if (link_rst)
      bit_cnt_q <= 7'h00;
    else if (fresh_q)
      bit_cnt_q <= 7'h01;
    else if (bit_cnt_q != 7'h7F)
      bit_cnt_q <= bit_cnt_q + 7'h01;
  end
  // bytes stay frozen after cs rises, so the core reads them safely
  for (genvar g = 0; g < NBYTES; g++)
  begin : g_byte
    always_ff @(posedge sck_in or posedge link_rst)
    begin
      if (link_rst)
        frame_bytes_q[g] <= 8'h00;
      else if (wr_idx == 4'(g))
        frame_bytes_q[g][wr_bit] <= mosi_in;
    end
  end
  logic              cs_meta_q;
  logic              cs_sync_q;
  logic              cs_prev_q;
  logic [1:0]        lock_meta_q;
  logic [1:0]        lock_q;
  always_ff @(posedge clk_in or posedge link_rst)
  begin
    if (link_rst)
    begin
      cs_meta_q   <= 1'b1;
      cs_sync_q   <= 1'b1;
      cs_prev_q   <= 1'b1;
      lock_meta_q <= 2'h0;
      lock_q      <= 2'h0;
    end
    else
    begin
      cs_meta_q   <= cs_n_in;
      cs_sync_q   <= cs_meta_q;
      cs_prev_q   <= cs_sync_q;
      lock_meta_q <= region_lock_bits_in;
      lock_q      <= lock_meta_q;
    end
  end
  rwlm_state_e       state_q;
  logic [14:0]       timer_q;
  logic              hold_q;
  rwlm_status_s      status_q;
  logic [7:0]        pr_q;
  logic [7:0]        cfg_q;
  logic [63:0]       pw_q;
  logic [7:0]        ptr_q;
  rwlm_access_s      access_q;
  logic [63:0]       pw_in;
  logic [7:0]        reg_view;
  rwlm_mode_e        mode;
  assign mode = mode_of(cfg_q);
  wire               frame_end = cs_sync_q & ~cs_prev_q;
  wire               frame_ok  = frame_end & (bit_cnt_q != 7'h00)
                                 & (bit_cnt_q[2:0] == 3'h0);
  wire [3:0]         nbytes    = bit_cnt_q[6:3];
  wire [7:0]         opc       = frame_bytes_q[0];
  wire [7:0]         arg       = frame_bytes_q[1];
  wire [7:0]         val       = frame_bytes_q[2];
  wire               accept    = frame_ok & (state_q == RWLM_ST_IDLE);
  wire [2:0]         mode_clr  = ~val[2:0];
  wire               is_pass_addr = arg[7:3] == 5'(`RWLM_ADDR_PASS_BASE >> 3);
  wire               pw_ok     = mode != RWLM_MODE_PASSWORD;
  wire               region_ok = ~arg[1] | (pr_q[`RWLM_PR_UNLOCK_BIT]
                                 & ~lock_q[arg[0]]);
  always_comb
  begin
    for (int k = 0; k < 8; k++)
      pw_in[8*k +: 8] = frame_bytes_q[k+1];
  end
  always_comb
  begin
    reg_view = 8'h00;
    case (arg)
      `RWLM_ADDR_CFG:    reg_view = cfg_q;
      `RWLM_ADDR_PR:     reg_view = pr_q;
      `RWLM_ADDR_PTR:    reg_view = ptr_q;
      `RWLM_ADDR_STATUS: reg_view = {5'h00, status_q};
      default:
        if (is_pass_addr)
          reg_view = pw_ok ? pw_q[8*arg[2:0] +: 8] : 8'hFF;
    endcase
  end
  // config, password and pointer storage, reset only at power-on
  always_ff @(posedge clk_in or posedge por_in)
  begin
    if (por_in)
    begin
      cfg_q <= `RWLM_CFG_RESET;
      pw_q  <= `RWLM_PASS_RESET;
      ptr_q <= `RWLM_PTR_RESET;
    end
    else if (accept)
    begin
      if (opc == `RWLM_OP_PASS_PROG && nbytes == 4'h9 && pw_ok)
        pw_q <= pw_q & pw_in;
      if (opc == `RWLM_OP_REG_WRITE && nbytes == 4'h3)
      begin
        if (arg == `RWLM_ADDR_CFG && cfg_q[2:0] == 3'h7
            && (mode_clr & (mode_clr - 3'h1)) == 3'h0)
          cfg_q <= cfg_q & (val | ~`RWLM_CFG_MASK);
        if (arg == `RWLM_ADDR_PTR && pr_q[`RWLM_PR_UNLOCK_BIT])
          ptr_q <= val;
        if (is_pass_addr && pw_ok)
          pw_q[8*arg[2:0] +: 8] <= pw_q[8*arg[2:0] +: 8] & val;
      end
    end
  end
  // command sequencing, status and volatile protection state
  always_ff @(posedge clk_in or posedge link_rst)
  begin
    if (link_rst)
    begin
      state_q  <= RWLM_ST_INIT;
      timer_q  <= 15'h0000;
      hold_q   <= 1'b0;
      status_q <= '0;
      pr_q     <= `RWLM_PR_RESET;
      per_block_lock_protect_out <= 1'b1;
      register_read_data_out     <= 8'h00;
      password_read_data_out     <= 64'h0;
      frame_reject_out           <= 1'b0;
    end
    else
    begin
      frame_reject_out <= frame_end & ~frame_ok;
      case (state_q)
        RWLM_ST_INIT:
        begin
          pr_q[`RWLM_PR_UNLOCK_BIT] <= mode == RWLM_MODE_SUPPLY;
          pr_q[`RWLM_PR_R3READ_BIT] <= (mode == RWLM_MODE_PASSWORD)
                                     ? cfg_q[`RWLM_CFG_R3READ_BIT]
                                     : 1'b1;
          per_block_lock_protect_out <= cfg_q[`RWLM_CFG_BOOT_BIT];
          state_q <= RWLM_ST_IDLE;
        end
        RWLM_ST_IDLE:
        begin
          if (accept)
          begin
            case (opc)
              `RWLM_OP_RELOCK:
                if (nbytes == 4'h1)
                  pr_q[`RWLM_PR_UNLOCK_BIT] <= 1'b0;
              `RWLM_OP_PASS_UNLOCK:
                if (nbytes == 4'h9 && mode == RWLM_MODE_PASSWORD)
                begin
                  status_q.busy <= 1'b1;
                  state_q       <= RWLM_ST_BUSY;
                  if (pw_in == pw_q)
                  begin
                    pr_q[`RWLM_PR_UNLOCK_BIT] <= 1'b1;
                    timer_q <= 15'h0000;
                    hold_q  <= 1'b0;
                  end
                  else
                  begin
                    status_q.prog_err <= 1'b1;
                    timer_q <= 15'(RATE_CYCLES - 1);
                    hold_q  <= 1'b1;
                  end
                end
              `RWLM_OP_PASS_PROG:
                if (nbytes == 4'h9 && pw_ok)
                begin
                  status_q.busy <= 1'b1;
                  state_q       <= RWLM_ST_BUSY;
                  timer_q       <= 15'(PROG_CYCLES - 1);
                  hold_q        <= 1'b0;
                end
              `RWLM_OP_PASS_READ:
                if (nbytes == 4'h1 && pw_ok)
                  password_read_data_out <= pw_q;
              `RWLM_OP_REG_READ:
                if (nbytes == 4'h2)
                  register_read_data_out <= reg_view;
              `RWLM_OP_REG_WRITE:
                if (nbytes == 4'h3)
                begin
                  if ((arg == `RWLM_ADDR_CFG && (cfg_q[2:0] != 3'h7
                       || (mode_clr & (mode_clr - 3'h1)) != 3'h0))
                      || (arg == `RWLM_ADDR_PTR
                       && !pr_q[`RWLM_PR_UNLOCK_BIT]))
                  begin
                    status_q.busy     <= 1'b1;
                    status_q.prog_err <= 1'b1;
                    state_q           <= RWLM_ST_HOLD;
                  end
                  else if (arg == `RWLM_ADDR_CFG || arg == `RWLM_ADDR_PTR
                           || (is_pass_addr && pw_ok))
                  begin
                    status_q.busy <= 1'b1;
                    state_q       <= RWLM_ST_BUSY;
                    timer_q       <= 15'(PROG_CYCLES - 1);
                    hold_q        <= 1'b0;
                  end
                end
              `RWLM_OP_SEC_PROG,
              `RWLM_OP_SEC_ERASE:
                if (nbytes == 4'h2)
                begin
                  status_q.busy <= 1'b1;
                  if (region_ok)
                  begin
                    state_q <= RWLM_ST_BUSY;
                    timer_q <= 15'(PROG_CYCLES - 1);
                    hold_q  <= 1'b0;
                  end
                  else
                  begin
                    state_q <= RWLM_ST_HOLD;
                    if (opc == `RWLM_OP_SEC_PROG)
                      status_q.prog_err <= 1'b1;
                    else
                      status_q.erase_err <= 1'b1;
                  end
                end
              `RWLM_OP_SOFT_RESET:
                if (nbytes == 4'h1)
                begin
                  per_block_lock_protect_out <= cfg_q[`RWLM_CFG_BOOT_BIT];
                  if (mode == RWLM_MODE_PASSWORD)
                    pr_q[`RWLM_PR_R3READ_BIT] <=
                      cfg_q[`RWLM_CFG_R3READ_BIT];
                end
              `RWLM_OP_CLR_STATUS:
                if (nbytes == 4'h1)
                begin
                  status_q.prog_err  <= 1'b0;
                  status_q.erase_err <= 1'b0;
                end
              default:
                ;
            endcase
          end
        end
        RWLM_ST_BUSY:
        begin
          if (timer_q == 15'h0000)
          begin
            state_q       <= hold_q ? RWLM_ST_HOLD : RWLM_ST_IDLE;
            status_q.busy <= hold_q;
          end
          else
            timer_q <= timer_q - 15'h0001;
        end
        RWLM_ST_HOLD:
        begin
          if (frame_ok && opc == `RWLM_OP_CLR_STATUS && nbytes == 4'h1)
          begin
            status_q  <= '0;
            state_q   <= RWLM_ST_IDLE;
          end
        end
        default:
          state_q <= RWLM_ST_IDLE;
      endcase
      if (mode == RWLM_MODE_PERMANENT)
      begin
        pr_q[`RWLM_PR_UNLOCK_BIT] <= 1'b0;
        pr_q[`RWLM_PR_R3READ_BIT] <= 1'b1;
      end
    end
  end
  // host-visible protection decisions for the array datapath
  always_ff @(posedge clk_in or posedge link_rst)
  begin
    if (link_rst)
      access_q <= '0;
    else
    begin
      access_q.region2_write_allow <= pr_q[`RWLM_PR_UNLOCK_BIT]
                                    & ~lock_q[0];
      access_q.region3_write_allow <= pr_q[`RWLM_PR_UNLOCK_BIT]
                                    & ~lock_q[1];
      access_q.pointer_write_allow <= pr_q[`RWLM_PR_UNLOCK_BIT];
      access_q.region3_read_valid  <= pr_q[`RWLM_PR_R3READ_BIT];
    end
  end
  assign status_out                    = status_q;
  assign access_out                    = access_q;
  assign volatile_protection_state_out = pr_q;
  assign protection_mode_config_out    = cfg_q;
  assign pointer_boundary_register_out = ptr_q;

endmodule : rwlm_region_write_lock_manager

// ==== rwlm_region_write_lock_manager_asserts.sv ====
// port checker for the region write lock manager
`timescale 1ns/1ps
module rwlm_region_write_lock_manager_asserts (
  input wire logic            clk_in,
  input wire logic            rst_in,
  input wire logic            por_in,
  input wire logic [1:0]      region_lock_bits_in,
  input rwlm_pkg::rwlm_status_s status_out,
  input rwlm_pkg::rwlm_access_s access_out,
  input wire logic [7:0]      volatile_protection_state_out,
  input wire logic [7:0]      protection_mode_config_out,
  input wire logic            frame_reject_out
);
  import rwlm_pkg::*;
  wire [7:0] pr  = volatile_protection_state_out;
  wire [7:0] cfg = protection_mode_config_out;
  wire       sup = cfg[0] & cfg[2];
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in || por_in);

  property p_ptr_locked;
    !pr[0] && !$past(pr[0]) |-> !access_out.pointer_write_allow;
  endproperty
  a_ptr_locked: assert property (p_ptr_locked)
    else $error("pointer write allowed while locked");
  property p_lock2;
    region_lock_bits_in[0] [*4] |-> !access_out.region2_write_allow;
  endproperty
  a_lock2: assert property (p_lock2)
    else $error("region 2 writable while its lock bit is set");
  property p_supply_reset;
    $fell(rst_in) && sup |=> pr[0];
  endproperty
  a_supply_reset: assert property (p_supply_reset)
    else $error("supply mode reset left write unlock low");
  property p_supply_hold;
    sup |-> !$rose(pr[0]);
  endproperty
  a_supply_hold: assert property (p_supply_hold)
    else $error("write unlock set again in supply mode");
  property p_pass_reset;
    $fell(rst_in) && !cfg[2] |=> !pr[0] && pr[6] == cfg[6];
  endproperty
  a_pass_reset: assert property (p_pass_reset)
    else $error("password mode reset state wrong");
  property p_perm;
    $fell(rst_in) && !cfg[0] |=> !pr[0] && pr[6];
  endproperty
  a_perm: assert property (p_perm)
    else $error("permanent mode state wrong after reset");
  property p_err_busy;
    status_out.prog_err |-> status_out.busy;
  endproperty
  a_err_busy: assert property (p_err_busy)
    else $error("program error without busy");
  property p_fast_unlock;
    $rose(pr[0]) && !cfg[2] |-> ##[0:4] !status_out.busy;
  endproperty
  a_fast_unlock: assert property (p_fast_unlock)
    else $error("busy stayed after good password");
  property p_cfg_frozen;
    $past(cfg[2:0]) != 3'h7 |-> $stable(cfg);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen)
    else $error("config changed after mode chosen");
  property p_read_lock;
    !pr[6] && !$past(pr[6]) |-> !access_out.region3_read_valid;
  endproperty
  a_read_lock: assert property (p_read_lock)
    else $error("region 3 read valid while disabled");
  property p_reject;
    frame_reject_out |=> !frame_reject_out;
  endproperty
  a_reject: assert property (p_reject)
    else $error("frame reject longer than one cycle");

  c_unlock: cover property ($rose(pr[0]) && !cfg[2]);
  c_err: cover property ($rose(status_out.prog_err));
  c_reject: cover property (frame_reject_out);
endmodule : rwlm_region_write_lock_manager_asserts

bind rwlm_region_write_lock_manager rwlm_region_write_lock_manager_asserts
  u_asserts (.clk_in, .rst_in, .por_in, .region_lock_bits_in, .status_out,
    .access_out, .volatile_protection_state_out,
    .protection_mode_config_out, .frame_reject_out);

// ==== rwlm_region_write_lock_manager_map.svh ====
// constants for the region write lock manager: opcodes, fields, timing
`ifndef RWLM_REGION_WRITE_LOCK_MANAGER_MAP_SVH
`define RWLM_REGION_WRITE_LOCK_MANAGER_MAP_SVH

`define RWLM_OP_RELOCK       8'hA6
`define RWLM_OP_PASS_UNLOCK  8'hEA
`define RWLM_OP_PASS_PROG    8'hE8
`define RWLM_OP_PASS_READ    8'hE7
`define RWLM_OP_REG_READ     8'h65
`define RWLM_OP_REG_WRITE    8'h71
`define RWLM_OP_SEC_PROG     8'h42
`define RWLM_OP_SEC_ERASE    8'h44
`define RWLM_OP_SOFT_RESET   8'h99
`define RWLM_OP_CLR_STATUS   8'h30

`define RWLM_ADDR_CFG        8'h00
`define RWLM_ADDR_PR         8'h01
`define RWLM_ADDR_PTR        8'h02
`define RWLM_ADDR_STATUS     8'h03
`define RWLM_ADDR_PASS_BASE  8'h20

`define RWLM_CFG_PERM_BIT    0
`define RWLM_CFG_SUPPLY_BIT  1
`define RWLM_CFG_PASS_BIT    2
`define RWLM_CFG_BOOT_BIT    4
`define RWLM_CFG_R3READ_BIT  6
`define RWLM_PR_UNLOCK_BIT   0
`define RWLM_PR_R3READ_BIT   6

`define RWLM_CFG_RESET       8'h57
`define RWLM_CFG_MASK        8'h57
`define RWLM_PR_RESET        8'h41
`define RWLM_PASS_RESET      64'hFFFF_FFFF_FFFF_FFFF
`define RWLM_PTR_RESET       8'hFF

`define RWLM_CLK_MHZ         40
`define RWLM_RATE_US         100
`define RWLM_RATE_CYCLES     (`RWLM_RATE_US * `RWLM_CLK_MHZ)
`define RWLM_PAGE_PROG_US    400
`define RWLM_PAGE_PROG_CYCLES (`RWLM_PAGE_PROG_US * `RWLM_CLK_MHZ)

`endif

// ==== rwlm_region_write_lock_manager_tb.sv ====
// self-checking bench for the region write lock manager
`timescale 1ns/1ps
module rwlm_region_write_lock_manager_tb;
  import rwlm_pkg::*;
  localparam logic [63:0] PW = 64'h0123_4567_89AB_CDEF;
  logic         clk_in;
  logic         rst_in;
  logic         por_in;
  logic         sck;
  logic         cs_n;
  logic         mosi;
  logic [1:0]   lock;
  rwlm_status_s st;
  rwlm_access_s acc;
  logic [7:0]   pr;
  logic [7:0]   cfg;
  logic         pbl;
  logic [7:0]   rd;
  logic [63:0]  pwd;
  logic [7:0]   ptr;
  logic         rej;
  int           n_mismatch = 0;
  int           tests_run = 0;
  int           cyc = 0;
  int           rej_cnt = 0;

  rwlm_spi_host host (.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi));

  rwlm_region_write_lock_manager #(.PROG_CYCLES(20), .RATE_CYCLES(200)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .por_in(por_in), .sck_in(sck),
    .cs_n_in(cs_n), .mosi_in(mosi), .region_lock_bits_in(lock),
    .status_out(st), .access_out(acc),
    .volatile_protection_state_out(pr), .protection_mode_config_out(cfg),
    .pointer_boundary_register_out(ptr), .per_block_lock_protect_out(pbl),
    .register_read_data_out(rd), .password_read_data_out(pwd),
    .frame_reject_out(rej));

  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic results;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  always @(negedge clk_in)
  begin
    cyc++;
    if (rej === 1'b1)
      rej_cnt++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic sf(input logic [71:0] d, input int nb);
    host.xfer(d, nb);
    repeat (8) @(negedge clk_in);
  endtask : sf

  task automatic idle;
    int k;
    k = 0;
    while (st.busy !== 1'b0 && k < 100)
    begin
      @(negedge clk_in);
      k++;
    end
    chk("busy", 0, st.busy);
  endtask : idle

  task automatic hw(input logic p);
    @(negedge clk_in);
    rst_in = 1'b1;
    por_in = p;
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    por_in = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask : hw

  function automatic logic [63:0] bsw(input logic [63:0] v);
    for (int i = 0; i < 8; i++)
      bsw[8*i +: 8] = v[56-8*i +: 8];
  endfunction : bsw

  initial
  begin
    rst_in = 1'b1;
    por_in = 1'b1;
    lock = 2'h0;
    hw(1'b1);
    chk("cfg", 8'h57, cfg);
    chk("pr", 8'h41, pr);
    chk("boot lock", 1, pbl);
    chk("access", 4'hF, acc);
    lock = 2'h1;
    repeat (5) @(negedge clk_in);
    chk("access", 4'h7, acc);
    lock = 2'h0;
    sf(72'h7F, 7);
    chk("reject", 1, rej_cnt);
    sf({8'h65, 8'h20}, 16);
    chk("gen read", 8'hFF, rd);
    sf({8'hE8, bsw(PW)}, 72);
    idle();
    sf({8'hE8, 64'hFFFF_FFFF_FFFF_FFFF}, 72);
    idle();
    sf(8'hE7, 8);
    chk("password", PW, pwd);
    sf({8'h65, 8'h20}, 16);
    chk("gen read", 8'hEF, rd);
    sf({8'h71, 8'h02, 8'h5A}, 24);
    idle();
    chk("pointer", 8'h5A, ptr);
    sf({8'h42, 8'h02}, 16);
    chk("status", 3'h1, st);
    idle();
    sf(8'hA6, 8);
    chk("pr", 8'h40, pr);
    chk("access", 4'h1, acc);
    sf({8'h71, 8'h02, 8'h33}, 24);
    chk("status", 3'h3, st);
    chk("pointer", 8'h5A, ptr);
    sf(8'h30, 8);
    sf({8'h44, 8'h03}, 16);
    chk("status", 3'h5, st);
    sf(8'h30, 8);
    sf({8'h42, 8'h02}, 16);
    chk("status", 3'h3, st);
    sf(8'h30, 8);
    chk("status", 3'h0, st);
    sf(8'h99, 8);
    chk("pr", 8'h40, pr);
    hw(1'b0);
    chk("pr", 8'h41, pr);
    sf({8'h71, 8'h00, 8'h03}, 24);
    chk("busy", 1, st.busy);
    idle();
    chk("cfg", 8'h03, cfg);
    sf({8'h71, 8'h00, 8'h02}, 24);
    chk("status", 3'h3, st);
    sf(8'h30, 8);
    hw(1'b0);
    chk("pr", 8'h00, pr);
    chk("boot lock", 0, pbl);
    chk("access", 4'h0, acc);
    sf({8'hE8, 64'h0}, 72);
    chk("status", 3'h0, st);
    sf(8'hE7, 8);
    chk("password", 0, pwd);
    sf({8'hEA, bsw(~PW)}, 72);
    chk("status", 3'h3, st);
    sf({8'hEA, bsw(PW)}, 72);
    chk("pr", 8'h00, pr);
    repeat (220) @(negedge clk_in);
    chk("busy", 1, st.busy);
    sf(8'h30, 8);
    sf({8'hEA, bsw(PW)}, 72);
    chk("pr", 8'h01, pr);
    chk("status", 3'h0, st);
    sf(8'h99, 8);
    chk("pr", 8'h01, pr);
    sf(8'hA6, 8);
    chk("pr", 8'h00, pr);
    hw(1'b1);
    sf({8'h71, 8'h00, 8'h56}, 24);
    idle();
    hw(1'b0);
    chk("pr", 8'h40, pr);
    chk("access", 4'h1, acc);
    results();
  end
endmodule : rwlm_region_write_lock_manager_tb

// ==== rwlm_spi_host.sv ====
// spi host model that sends command frames of nb bits
`timescale 1ns/1ps
module rwlm_spi_host (
  output logic sck_out,
  output logic cs_n_out,
  output logic mosi_out
);
  initial
  begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b1;
  end

  // clock only inside the frame, select held over all bits
  task automatic xfer(input logic [71:0] d, input int nb);
    cs_n_out = 1'b0;
    #24;
    for (int i = nb - 1; i >= 0; i--)
    begin
      mosi_out = d[i];
      #24 sck_out = 1'b1;
      #24 sck_out = 1'b0;
    end
    #24 cs_n_out = 1'b1;
    // released data line must not look like the last bit
    mosi_out = ~mosi_out;
  endtask : xfer
endmodule : rwlm_spi_host
